//--- pkg/mmd_defines.svh
// constants for the memory map decoder
// assumes a 16-bit cpu address space
`ifndef MMD_DEFINES_SVH
`define MMD_DEFINES_SVH
`define MMD_IO_LO 16'h0000
`define MMD_IO_HI 16'h007f
`define MMD_GAP_LO 16'h0080
`define MMD_RAM_LO 16'h0090
`define MMD_DIR_HI 16'h00ff
`define MMD_EXT_LO 16'h0100
`define MMD_EXT_HI_L 16'h047f
`define MMD_EXT_HI_M 16'h027f
`define MMD_EXT_HI_S 16'h017f
`define MMD_GPR_HI_ML 16'h01ff
`define MMD_GPR_HI_S 16'h017f
`define MMD_XIO_LO 16'h0f80
`define MMD_XIO_HI 16'h0fff
`define MMD_FL_LO 16'hb000
`define MMD_FL_4K_END 16'hbfff
`define MMD_FL_S_HI_LO 16'hf000
`define MMD_FL_M_HI_LO 16'he000
`define MMD_NVR_LO 16'hffbc
`define MMD_NVR_HI 16'hffbf
`define MMD_VEC_LO 16'hffc0
`define MMD_VEC_HI 16'hffff
`define MMD_MODE_ADDR 16'hfffd
`define MMD_MODE_SINGLE 8'h00
`define MMD_RAM_SZ_S 16'd240
`define MMD_RAM_SZ_M 16'd496
`define MMD_RAM_SZ_L 16'd1008
`endif

//--- pkg/mmd_pkg.sv
// types shared by the memory map decoder
// assumes mmd_defines.svh for the numeric constants
package mmd_pkg;
  typedef enum logic [1:0] {
    MMD_VAR_SMALL = 2'b00,
    MMD_VAR_MEDIUM = 2'b01,
    MMD_VAR_LARGE = 2'b10
  } mmd_variant_t;

  typedef enum logic [2:0] {
    MMD_REG_PROHIBITED = 3'b000,
    MMD_REG_IO = 3'b001,
    MMD_REG_XIO = 3'b010,
    MMD_REG_RAM = 3'b011,
    MMD_REG_NVR = 3'b100,
    MMD_REG_VECTOR = 3'b101,
    MMD_REG_FLASH = 3'b110
  } mmd_region_t;

  typedef struct packed {
    mmd_region_t region;
    logic direct;
    logic ext_direct;
    logic gp_reg;
    logic violation;
  } mmd_decode_t;

  typedef enum logic [1:0] {
    MMD_BOOT_MODE = 2'b00,
    MMD_BOOT_VECTOR = 2'b01,
    MMD_BOOT_RUN = 2'b10,
    MMD_BOOT_HALT = 2'b11
  } mmd_boot_t;
endpackage : mmd_pkg

//--- rtl/mmd_decoder.sv
// memory map decoder: classifies cpu addresses, sequences the boot fetch,
// and selects the reset pin function.
// assumes cpu address and strobe come from logic on the same clock.
`include "mmd_defines.svh"

module mmd_decoder
  import mmd_pkg::*;
#(
  parameter mmd_variant_t VARIANT = MMD_VAR_LARGE
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_access,
  input wire logic [7:0] cpu_rdata,
  input wire logic reset_output_enable_bit,
  input wire logic reset_pin_function_select,
  input wire logic port_f_bit2_out,
  input wire logic port_f_bit2_dir,
  input wire logic internal_reset_req,
  input wire logic pin_rst_in,
  output logic pin_rst_out,
  output logic pin_rst_oe_n,
  output logic pin_reset_req,
  output logic port_f_bit2_in,
  output mmd_decode_t dec_q,
  output logic access_violation_q,
  output logic [15:0] boot_fetch_addr,
  output mmd_boot_t boot_state_q,
  output logic mode_error_q
);

  // variant dependent limits
  localparam logic [15:0] RAM_HI = (VARIANT == MMD_VAR_SMALL) ? `MMD_RAM_LO + `MMD_RAM_SZ_S - 16'd1 :
                                   (VARIANT == MMD_VAR_MEDIUM) ? `MMD_RAM_LO + `MMD_RAM_SZ_M - 16'd1 :
                                   `MMD_RAM_LO + `MMD_RAM_SZ_L - 16'd1;
  localparam logic [15:0] EXT_HI = (VARIANT == MMD_VAR_SMALL) ? `MMD_EXT_HI_S :
                                   (VARIANT == MMD_VAR_MEDIUM) ? `MMD_EXT_HI_M : `MMD_EXT_HI_L;
  localparam logic [15:0] GPR_HI = (VARIANT == MMD_VAR_SMALL) ? `MMD_GPR_HI_S : `MMD_GPR_HI_ML;
  localparam logic [15:0] FL_HI_LO = (VARIANT == MMD_VAR_SMALL) ? `MMD_FL_S_HI_LO :
                                     (VARIANT == MMD_VAR_MEDIUM) ? `MMD_FL_M_HI_LO : `MMD_FL_LO;

  wire logic in_io = cpu_addr <= `MMD_IO_HI;
  wire logic in_xio = (cpu_addr >= `MMD_XIO_LO) && (cpu_addr <= `MMD_XIO_HI);
  wire logic in_ram = (cpu_addr >= `MMD_RAM_LO) && (cpu_addr <= RAM_HI);
  wire logic in_gap = (cpu_addr >= `MMD_GAP_LO) && (cpu_addr < `MMD_RAM_LO);
  wire logic in_dir = (cpu_addr >= `MMD_RAM_LO) && (cpu_addr <= `MMD_DIR_HI);
  wire logic in_ext = (cpu_addr >= `MMD_EXT_LO) && (cpu_addr <= EXT_HI);
  wire logic in_gpr = (cpu_addr >= `MMD_EXT_LO) && (cpu_addr <= GPR_HI);
  wire logic in_vec = cpu_addr >= `MMD_VEC_LO;
  wire logic in_nvr = (cpu_addr >= `MMD_NVR_LO) && (cpu_addr <= `MMD_NVR_HI);
  // the small and medium parts carry a 4 Kbyte block at b000 and a top block
  wire logic in_fl_low = (VARIANT != MMD_VAR_LARGE) && (cpu_addr >= `MMD_FL_LO) &&
                         (cpu_addr <= `MMD_FL_4K_END);
  wire logic in_flash = in_fl_low || (cpu_addr >= FL_HI_LO);

  mmd_region_t region_c;
  always_comb begin
    if (in_io) begin
      region_c = MMD_REG_IO;
    end else if (in_ram) begin
      region_c = MMD_REG_RAM;
    end else if (in_xio) begin
      region_c = MMD_REG_XIO;
    end else if (in_vec) begin
      region_c = MMD_REG_VECTOR;
    end else if (in_nvr) begin
      region_c = MMD_REG_NVR;
    end else if (in_flash) begin
      region_c = MMD_REG_FLASH;
    end else begin
      region_c = MMD_REG_PROHIBITED;
    end
  end

  mmd_decode_t dec_d;
  assign dec_d.region = region_c;
  assign dec_d.direct = in_io || in_dir;
  assign dec_d.ext_direct = in_ext;
  assign dec_d.gp_reg = in_gpr;
  assign dec_d.violation = cpu_access && (region_c == MMD_REG_PROHIBITED);

  // registered so the decode lines up with the cpu data phase
  always_ff @(posedge clock) begin
    if (reset) begin
      dec_q <= '0;
      access_violation_q <= 1'b0;
    end else if (cpu_access) begin
      dec_q <= dec_d;
      access_violation_q <= dec_d.violation;
    end else begin
      access_violation_q <= 1'b0;
    end
  end

  // boot fetch: mode byte first, then the reset vector high and low bytes
  mmd_boot_t boot_state_d;
  logic vec_lo_q;
  logic vec_lo_d;
  always_comb begin
    boot_state_d = boot_state_q;
    vec_lo_d = vec_lo_q;
    unique case (boot_state_q)
      MMD_BOOT_MODE: begin
        if (cpu_access) begin
          boot_state_d = (cpu_rdata == `MMD_MODE_SINGLE) ? MMD_BOOT_VECTOR : MMD_BOOT_HALT;
        end
      end
      MMD_BOOT_VECTOR: begin
        if (cpu_access) begin
          vec_lo_d = 1'b1;
          if (vec_lo_q) begin
            boot_state_d = MMD_BOOT_RUN;
          end
        end
      end
      MMD_BOOT_RUN: begin
        boot_state_d = MMD_BOOT_RUN;
      end
      MMD_BOOT_HALT: begin
        boot_state_d = MMD_BOOT_HALT;
      end
    endcase
  end

  // vector at fffe/ffff follows the mode byte
  assign boot_fetch_addr = (boot_state_q == MMD_BOOT_MODE) ? `MMD_MODE_ADDR :
                           vec_lo_q ? `MMD_VEC_HI : (`MMD_MODE_ADDR + 16'd1);

  always_ff @(posedge clock) begin
    if (reset) begin
      boot_state_q <= MMD_BOOT_MODE;
      vec_lo_q <= 1'b0;
      mode_error_q <= 1'b0;
    end else begin
      boot_state_q <= boot_state_d;
      vec_lo_q <= vec_lo_d;
      mode_error_q <= boot_state_d == MMD_BOOT_HALT;
    end
  end

  // reset pin: synchronise the pad, then select reset or port function
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= 1'b1;
    end else begin
      rst_meta_q <= pin_rst_in;
      rst_sync_q <= rst_meta_q;
    end
  end

  // both select bits come up set, so the pin starts as a bidirectional reset
  wire logic drive_reset = reset_pin_function_select && reset_output_enable_bit && internal_reset_req;
  wire logic drive_port = !reset_pin_function_select && port_f_bit2_dir && !port_f_bit2_out;
  // open drain: only ever pulls low
  assign pin_rst_out = 1'b0;
  assign pin_rst_oe_n = !(drive_reset || drive_port);
  assign pin_reset_req = reset_pin_function_select && !rst_sync_q;
  assign port_f_bit2_in = rst_sync_q;

  AST_IO_DIRECT: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr <= `MMD_IO_HI |=> dec_q.region == MMD_REG_IO && dec_q.direct)
    else $error("io window decode wrong");
  AST_XIO: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr >= `MMD_XIO_LO && cpu_addr <= `MMD_XIO_HI |=> dec_q.region == MMD_REG_XIO && !dec_q.direct)
    else $error("extended io decode wrong");
  AST_DIRECT_RAM: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr >= `MMD_RAM_LO && cpu_addr <= `MMD_DIR_HI |=> dec_q.direct && dec_q.region == MMD_REG_RAM)
    else $error("direct ram decode wrong");
  AST_EXT_END: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr == EXT_HI |=> dec_q.ext_direct)
    else $error("extended direct window end wrong");
  AST_GPR_END: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr == GPR_HI + 16'd1 |=> !dec_q.gp_reg)
    else $error("register bank area too long");
  AST_VECTOR: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr >= `MMD_VEC_LO |=> dec_q.region == MMD_REG_VECTOR)
    else $error("vector table decode wrong");
  AST_NVR: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr >= `MMD_NVR_LO && cpu_addr <= `MMD_NVR_HI |=> dec_q.region == MMD_REG_NVR)
    else $error("nvr area decode wrong");
  AST_GAP: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr >= `MMD_GAP_LO && cpu_addr < `MMD_RAM_LO |=> access_violation_q)
    else $error("gap not prohibited");
  AST_RAM_END: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr == RAM_HI + 16'd1 && cpu_addr < `MMD_XIO_LO |=> access_violation_q)
    else $error("ram end decode wrong");
  AST_RST_PIN: assert property (@(posedge clock) disable iff (reset)
    reset_pin_function_select && reset_output_enable_bit && internal_reset_req |-> !pin_rst_oe_n)
    else $error("reset output not driven");

  sequence s_mode_ok;
    boot_state_q == MMD_BOOT_MODE && cpu_access && cpu_rdata == `MMD_MODE_SINGLE;
  endsequence
  sequence s_vector;
    boot_state_q == MMD_BOOT_VECTOR && boot_fetch_addr == `MMD_MODE_ADDR + 16'd1;
  endsequence
  AST_BOOT: assert property (@(posedge clock) disable iff (reset) s_mode_ok |=> s_vector)
    else $error("vector fetch not after mode byte");
  AST_FLASH_TOP: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr >= `MMD_FL_S_HI_LO && cpu_addr < `MMD_NVR_LO |=> dec_q.region == MMD_REG_FLASH)
    else $error("flash top decode wrong");

  // edge checks below pin the io, extended io, direct, extended direct, nvr and ram window edges, where an off-by-one would hide

  AST_IO_LOW: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr == `MMD_IO_LO |=> dec_q.region == MMD_REG_IO)
    else $error("io window start wrong");
  AST_XIO_EDGE: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr == `MMD_XIO_LO - 16'd1 |=> dec_q.region != MMD_REG_XIO)
    else $error("extended io starts too early");
  AST_DIR_END: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr == `MMD_EXT_LO |=> !dec_q.direct)
    else $error("short direct window too long");
  AST_EXT_START: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr == `MMD_EXT_LO |=> dec_q.ext_direct && dec_q.gp_reg)
    else $error("extended direct window start wrong");
  AST_EXT_PAST: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr == EXT_HI + 16'd1 |=> !dec_q.ext_direct)
    else $error("extended direct window too long");
  AST_GPR_RAM: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr >= `MMD_EXT_LO && cpu_addr <= GPR_HI |=> dec_q.region == MMD_REG_RAM && dec_q.gp_reg)
    else $error("register bank area not ram");
  AST_NVR_EDGE: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr == `MMD_NVR_LO - 16'd1 |=> dec_q.region == MMD_REG_FLASH)
    else $error("nvr area starts too early");
  AST_GAP_REGION: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr >= `MMD_GAP_LO && cpu_addr < `MMD_RAM_LO |=> dec_q.region == MMD_REG_PROHIBITED)
    else $error("gap region code wrong");
  AST_RAM_LAST: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr == RAM_HI |=> dec_q.region == MMD_REG_RAM)
    else $error("ram ends too early");

  // violation is a pulse tied to an access; the decode itself holds between accesses
  AST_VIOL_FLAG: assert property (@(posedge clock) disable iff (reset)
    cpu_access && region_c == MMD_REG_PROHIBITED |=> access_violation_q && dec_q.violation)
    else $error("violation not flagged");
  AST_VIOL_PULSE: assert property (@(posedge clock) disable iff (reset)
    !cpu_access |=> !access_violation_q)
    else $error("violation without access");
  AST_DEC_HOLD: assert property (@(posedge clock) disable iff (reset)
    !cpu_access |=> $stable(dec_q))
    else $error("decode changed without access");
  AST_FLASH_BASE: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr == `MMD_FL_LO |=> dec_q.region == MMD_REG_FLASH)
    else $error("flash base decode wrong");
  AST_FLASH_GAP: assert property (@(posedge clock) disable iff (reset)
    cpu_access && cpu_addr == `MMD_FL_4K_END + 16'd1 |=>
    dec_q.region == ((VARIANT == MMD_VAR_LARGE) ? MMD_REG_FLASH : MMD_REG_PROHIBITED))
    else $error("flash gap decode wrong");

  // pin function: port mode never reports a pin reset
  AST_PORT_NO_REQ: assert property (@(posedge clock) disable iff (reset)
    !reset_pin_function_select |-> !pin_reset_req)
    else $error("pin reset reported in port mode");
  AST_RST_OUT_OFF: assert property (@(posedge clock) disable iff (reset)
    reset_pin_function_select && !reset_output_enable_bit |-> pin_rst_oe_n)
    else $error("reset pin driven while output disabled");

  // boot steps after the mode byte
  sequence s_mode_bad;
    boot_state_q == MMD_BOOT_MODE && cpu_access && cpu_rdata != `MMD_MODE_SINGLE;
  endsequence
  sequence s_vec_hi;
    boot_state_q == MMD_BOOT_VECTOR && cpu_access && !vec_lo_q;
  endsequence
  sequence s_vec_lo;
    boot_state_q == MMD_BOOT_VECTOR && boot_fetch_addr == `MMD_VEC_HI;
  endsequence
  AST_MODE_BAD: assert property (@(posedge clock) disable iff (reset)
    s_mode_bad |=> boot_state_q == MMD_BOOT_HALT && mode_error_q)
    else $error("bad mode byte not halted");
  AST_VEC_LOW: assert property (@(posedge clock) disable iff (reset)
    s_vec_hi |=> s_vec_lo)
    else $error("low vector byte not fetched next");
  AST_HALT_HOLD: assert property (@(posedge clock) disable iff (reset)
    boot_state_q == MMD_BOOT_HALT |=> boot_state_q == MMD_BOOT_HALT && mode_error_q)
    else $error("halt left without reset");
  AST_RUN_HOLD: assert property (@(posedge clock) disable iff (reset)
    boot_state_q == MMD_BOOT_RUN |=> boot_state_q == MMD_BOOT_RUN && !mode_error_q)
    else $error("run left without reset");

endmodule : mmd_decoder

//--- tb/mmd_cpu_model.sv
// cpu-side model: presents one access per call, back to back on request
// assumes each call starts in the time step of a rising clock edge
module mmd_cpu_model (
  input wire logic clock,
  output logic [15:0] cpu_addr,
  output logic cpu_access,
  output logic [7:0] cpu_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cpu_addr = 16'h0000;
    cpu_access = 1'b0;
    cpu_rdata = 8'h00;
  end
  // released lines show the inverse, so a decoder reading idle lines cannot pass by luck
  task automatic access(input logic [15:0] addr, input logic [7:0] data, input bit last);
    cpu_addr <= addr;
    cpu_access <= 1'b1;
    cpu_rdata <= data;
    @(posedge clock);
    if (last) begin
      cpu_access <= 1'b0;
      cpu_addr <= ~addr;
      cpu_rdata <= ~data;
    end
  endtask : access
endmodule : mmd_cpu_model

//--- tb/memory_map_decoder_tb.sv
// self-checking bench for the memory map decoder, large variant
// assumes mmd_cpu_model as the cpu; the reset pad has an external pull-up
module memory_map_decoder_tb import mmd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [15:0] cpu_addr;
  logic cpu_access;
  logic [7:0] cpu_rdata;
  logic oe_bit = 1'b1, fsel = 1'b1, pf_out = 1'b1, pf_dir = 1'b0, ireq = 1'b0, pad_drv = 1'b1;
  logic pin_rst_in, pin_rst_out, pin_rst_oe_n, pin_reset_req, port_f_bit2_in;
  logic access_violation_q, mode_error_q, chk_q = 1'b0;
  logic [15:0] boot_fetch_addr, chk_addr_q = 16'h0000;
  mmd_decode_t dec_q;
  mmd_boot_t boot_state_q;
  mmd_region_t exp_r;
  int miscompares = 0, checks_done = 0, cycles = 0;
  always #50 clock = ~clock;
  // open drain pad: low when the pin is driven, else the external level
  assign pin_rst_in = pin_rst_oe_n ? pad_drv : pin_rst_out;
  mmd_decoder #(.VARIANT(MMD_VAR_LARGE)) dut (.clock(clock), .reset(reset), .cpu_addr(cpu_addr),
    .cpu_access(cpu_access), .cpu_rdata(cpu_rdata), .reset_output_enable_bit(oe_bit),
    .reset_pin_function_select(fsel), .port_f_bit2_out(pf_out), .port_f_bit2_dir(pf_dir),
    .internal_reset_req(ireq), .pin_rst_in(pin_rst_in), .pin_rst_out(pin_rst_out),
    .pin_rst_oe_n(pin_rst_oe_n), .pin_reset_req(pin_reset_req), .port_f_bit2_in(port_f_bit2_in),
    .dec_q(dec_q), .access_violation_q(access_violation_q), .boot_fetch_addr(boot_fetch_addr),
    .boot_state_q(boot_state_q), .mode_error_q(mode_error_q));
  mmd_cpu_model cpu (.clock(clock), .cpu_addr(cpu_addr), .cpu_access(cpu_access), .cpu_rdata(cpu_rdata));
  function automatic mmd_region_t ref_region(input logic [15:0] a);
    if (a <= 16'h007f) return MMD_REG_IO;
    if (a >= 16'h0090 && a <= 16'h047f) return MMD_REG_RAM;
    if (a >= 16'h0f80 && a <= 16'h0fff) return MMD_REG_XIO;
    if (a >= 16'hffc0) return MMD_REG_VECTOR;
    if (a >= 16'hffbc) return MMD_REG_NVR;
    if (a >= 16'hb000) return MMD_REG_FLASH;
    return MMD_REG_PROHIBITED;
  endfunction : ref_region
  task automatic chk(input bit ok, input string what);
    checks_done++;
    if (!ok) begin
      miscompares++;
      $display("[FAIL] %0t ns: %s", $time, what);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clock) begin
    chk_q <= cpu_access && !reset;
    chk_addr_q <= cpu_addr;
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // every access is judged one cycle later against the reference map
  always @(negedge clock) begin
    if (!reset && chk_q) begin
      exp_r = ref_region(chk_addr_q);
      chk(dec_q.region === exp_r, "region");
      chk(access_violation_q === (exp_r == MMD_REG_PROHIBITED), "violation flag");
      if (exp_r inside {MMD_REG_IO, MMD_REG_RAM}) begin
        chk(dec_q.direct === (chk_addr_q <= 16'h00ff), "direct flag");
        chk(dec_q.ext_direct === (chk_addr_q >= 16'h0100), "extended direct flag");
        chk(dec_q.gp_reg === (chk_addr_q inside {[16'h0100:16'h01ff]}), "bank flag");
      end
    end else if (!reset) begin
      chk(access_violation_q === 1'b0, "violation pulse too long");
    end
  end
  task automatic do_reset;
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    #1;
  endtask : do_reset
  task automatic acc(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    cpu.access(a, d, 1'b1);
    #1;
  endtask : acc
  task automatic pins(input logic [5:0] v);
    @(posedge clock);
    {oe_bit, fsel, pf_out, pf_dir, ireq, pad_drv} <= v;
    #1;
  endtask : pins
  task automatic test_pin;
    pins(6'b110001);
    repeat (2) @(posedge clock);
    #1 chk(pin_rst_oe_n === 1'b1 && pin_reset_req === 1'b0, "idle pin");
    pins(6'b110000);
    @(posedge clock);
    #1 chk(pin_reset_req === 1'b0, "pin reset seen too early");
    @(posedge clock);
    #1 chk(pin_reset_req === 1'b1, "pin reset missed");
    pins(6'b110011);
    chk(pin_rst_oe_n === 1'b0, "internal reset not driven out");
    pins(6'b010011);
    chk(pin_rst_oe_n === 1'b1, "reset driven while output disabled");
    pins(6'b000101);
    chk(pin_rst_oe_n === 1'b0, "port low not driven");
    repeat (2) @(posedge clock);
    #1 chk(port_f_bit2_in === 1'b0 && pin_reset_req === 1'b0, "port mode pin");
    pins(6'b001101);
    repeat (2) @(posedge clock);
    #1 chk(pin_rst_oe_n === 1'b1 && port_f_bit2_in === 1'b1, "port high");
    pins(6'b110001);
    $display("test_pin done");
  endtask : test_pin
  task automatic test_decode;
    logic [15:0] tbl[$] = '{16'h0000, 16'h007f, 16'h0080, 16'h008f, 16'h0090, 16'h00ff, 16'h0100,
      16'h01ff, 16'h0200, 16'h047f, 16'h0480, 16'h0f7f, 16'h0f80, 16'h0fff, 16'h1000, 16'hafff,
      16'hb000, 16'hffbb, 16'hffbc, 16'hffbf, 16'hffc0, 16'hffff};
    @(posedge clock);
    foreach (tbl[i]) cpu.access(tbl[i], 8'h00, i == tbl.size() - 1);
    repeat (2) @(posedge clock);
    #1 chk(dec_q.region === MMD_REG_VECTOR, "decode not held");
    $display("test_decode done");
  endtask : test_decode
  task automatic test_boot(input logic [7:0] mode);
    do_reset();
    chk(boot_state_q === MMD_BOOT_MODE && boot_fetch_addr === 16'hfffd, "mode fetch");
    acc(16'hfffd, mode);
    if (mode == 8'h00) begin
      chk(boot_state_q === MMD_BOOT_VECTOR && boot_fetch_addr === 16'hfffe, "vector high");
      acc(16'hfffe, 8'hc3);
      chk(boot_state_q === MMD_BOOT_VECTOR && boot_fetch_addr === 16'hffff, "vector low");
      acc(16'hffff, 8'h3c);
      chk(boot_state_q === MMD_BOOT_RUN && mode_error_q === 1'b0, "run");
    end else begin
      acc(16'hfffe, 8'h00);
      acc(16'hffff, 8'h00);
      chk(boot_state_q === MMD_BOOT_HALT && mode_error_q === 1'b1, "bad mode byte");
    end
    $display("test_boot done");
  endtask : test_boot
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    test_pin();
    test_decode();
    test_boot(8'h00);
    test_boot(8'h01);
    tally_and_finish();
  end
endmodule : memory_map_decoder_tb
